// *** hdl/urxe_pkg.sv ***
// Purpose: Shared constants and types of the enhanced serial receive block.
// Assumes: APB word addressing, byte address equals register index times four.
// Notes: Index values below are register indices, not byte addresses.
package urxe_pkg;
   // Number of serial ports served by one block.
   localparam int unsigned URXE_PORTS = 2;
   localparam int unsigned URXE_AW = 12;
   // Register indices; byte address is index times four.
   localparam logic [9:0] URXE_IDX_STN_ADDR0 = 10'h0a9;
   localparam logic [9:0] URXE_IDX_STN_MASK0 = 10'h0b9;
   localparam logic [9:0] URXE_IDX_STN_ADDR1 = 10'h0aa;
   localparam logic [9:0] URXE_IDX_STN_MASK1 = 10'h0ba;
   localparam logic [9:0] URXE_IDX_CTRL0 = 10'h0c0;
   localparam logic [9:0] URXE_IDX_CTRL1 = 10'h0c1;
   localparam logic [9:0] URXE_IDX_STAT0 = 10'h0c2;
   localparam logic [9:0] URXE_IDX_DATA0 = 10'h0c4;
   localparam logic [9:0] URXE_IDX_DIV0 = 10'h0c6;
   localparam logic [9:0] URXE_IDX_DIV1 = 10'h0c7;
   localparam logic [9:0] URXE_IDX_IRQ_STAT = 10'h0c8;
   localparam logic [9:0] URXE_IDX_IRQ_MASK = 10'h0c9;
   // Control register field positions.
   localparam int unsigned URXE_CTRL_MODE_LSB = 0;
   localparam int unsigned URXE_CTRL_MPE = 2;
   localparam int unsigned URXE_CTRL_FCE = 3;
   localparam int unsigned URXE_CTRL_EN = 4;
   // Status register field positions.
   localparam int unsigned URXE_STAT_RC = 0;
   localparam int unsigned URXE_STAT_FAULT = 1;
   localparam int unsigned URXE_STAT_BIT9 = 2;
   // Reset values.
   localparam logic [7:0] URXE_ADDR_RST = 8'h00;
   localparam logic [7:0] URXE_MASK_RST = 8'h00;
   localparam logic [15:0] URXE_DIV_RST = 16'h0035;
   // Oversampling: last tick index of a bit (16 ticks per bit) and the start-bit middle.
   localparam logic [3:0] URXE_OVS_LAST = 4'hf;
   localparam logic [3:0] URXE_OVS_MID = 4'h7;

   typedef enum logic [1:0]
   {
      URXE_MODE_SYNC = 2'h0,
      URXE_MODE_1 = 2'h1,
      URXE_MODE_2 = 2'h2,
      URXE_MODE_3 = 2'h3
   } urxe_mode_t;

   // Receiver states, Gray coded along idle, start, data, stop.
   typedef enum logic [1:0]
   {
      URXE_ST_IDLE = 2'h0,
      URXE_ST_START = 2'h1,
      URXE_ST_DATA = 2'h3,
      URXE_ST_STOP = 2'h2
   } urxe_state_t;

   typedef struct packed
   {
      logic en;
      logic fce;
      logic mpe;
      urxe_mode_t mode;
   } urxe_cfg_t;

   typedef struct packed
   {
      logic stop;
      logic bit9;
      logic [7:0] data;
   } urxe_frame_t;
endpackage

// *** hdl/urxe_addr_match.sv ***
// Purpose: Compares a received address byte with the given and broadcast address.
// Assumes: Station address and mask come straight from registers.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module urxe_addr_match
(
   input wire logic [7:0] i_rx_addr,
   input wire logic [7:0] i_station,
   input wire logic [7:0] i_mask,
   output logic o_match
);
   logic given_hit;
   logic bcast_hit;

   // Given address: masked positions must equal the station bits.
   assign given_hit = ((i_rx_addr ^ i_station) & i_mask) == 8'h00;
   // Broadcast address: positions set in station OR mask must read one.
   assign bcast_hit = ((~i_rx_addr) & (i_station | i_mask)) == 8'h00;
   assign o_match = given_hit | bcast_hit;
endmodule
`default_nettype wire

// *** hdl/urxe_rx_engine.sv ***
// Purpose: Oversampling asynchronous receiver for modes 1, 2 and 3.
// Assumes: Line input is synchronous to the clock; mode 0 leaves it idle.
// Notes: Pulses mark the last data bit and the stop bit sample.
`timescale 1ns/1ps
`default_nettype none
module urxe_rx_engine
#(
   parameter int unsigned DIV_W = 16
)
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_rxd,
   input wire urxe_pkg::urxe_cfg_t i_cfg,
   input wire logic [DIV_W-1:0] i_div,
   output logic o_data_done,
   output logic o_stop_done,
   output urxe_pkg::urxe_frame_t o_frame
);
   import urxe_pkg::*;

   urxe_state_t state_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic [3:0] os_q;
   logic [3:0] bit_q;
   logic [3:0] last_bit;
   logic tick;
   logic active;

   // Mode 1 carries eight data bits, modes 2 and 3 nine.
   assign last_bit = (i_cfg.mode == URXE_MODE_1) ? 4'h7 : 4'h8;
   assign active = i_cfg.en && (i_cfg.mode != URXE_MODE_SYNC);
   assign tick = (div_cnt_q == i_div);

   // Oversampling tick divider, each port at its own rate.
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         div_cnt_q <= '0;
      else if (tick || !active)
         div_cnt_q <= '0;
      else
         div_cnt_q <= div_cnt_q + 1'b1;
   end

   // Frame sequencer; samples each bit in its middle.
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_q <= URXE_ST_IDLE;
         os_q <= 4'h0;
         bit_q <= 4'h0;
         o_frame <= '0;
         o_data_done <= 1'b0;
         o_stop_done <= 1'b0;
      end
      else
      begin
         o_data_done <= 1'b0;
         o_stop_done <= 1'b0;
         if (tick)
            os_q <= os_q + 1'b1;
         case (state_q)
            URXE_ST_IDLE:
            begin
               os_q <= 4'h0;
               bit_q <= 4'h0;
               if (active && !i_rxd)
                  state_q <= URXE_ST_START;
            end
            URXE_ST_START:
            begin
               if (!active)
                  state_q <= URXE_ST_IDLE;
               else if (tick && os_q == URXE_OVS_MID)
               begin
                  os_q <= 4'h0;
                  state_q <= i_rxd ? URXE_ST_IDLE : URXE_ST_DATA; // False start rejected.
               end
            end
            URXE_ST_DATA:
            begin
               if (!active)
                  state_q <= URXE_ST_IDLE;
               else if (tick && os_q == URXE_OVS_LAST)
               begin
                  if (bit_q == 4'h8)
                     o_frame.bit9 <= i_rxd;
                  else
                     o_frame.data[bit_q[2:0]] <= i_rxd;
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == last_bit)
                  begin
                     o_data_done <= 1'b1;
                     state_q <= URXE_ST_STOP;
                  end
               end
            end
            URXE_ST_STOP:
            begin
               if (!active)
                  state_q <= URXE_ST_IDLE;
               else if (tick && os_q == URXE_OVS_LAST)
               begin
                  o_frame.stop <= i_rxd;
                  o_stop_done <= 1'b1;
                  state_q <= URXE_ST_IDLE;
               end
            end
            default:
               state_q <= URXE_ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** hdl/urxe_rx_enh.sv ***
// Purpose: Two enhanced serial receivers with stop-bit checking and address filtering.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes: Receive-complete, stop-bit fault and interrupt flags clear by writing one.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module urxe_rx_enh
#(
   parameter int unsigned PORTS = 2,
   parameter int unsigned DIV_W = 16
)
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [PORTS-1:0] i_rxd,
   output logic o_irq
);
   import urxe_pkg::*;

   // Register selector codes shared by the read and write decoders.
   localparam logic [3:0] SEL_NONE = 4'h0;
   localparam logic [3:0] SEL_ADDR = 4'h1;
   localparam logic [3:0] SEL_MASK = 4'h2;
   localparam logic [3:0] SEL_CTRL = 4'h3;
   localparam logic [3:0] SEL_STAT = 4'h4;
   localparam logic [3:0] SEL_DATA = 4'h5;
   localparam logic [3:0] SEL_DIV = 4'h6;
   localparam logic [3:0] SEL_ISTAT = 4'h7;
   localparam logic [3:0] SEL_IMASK = 4'h8;

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.
   // Parameter values that the register map cannot serve are refused.
   if (PORTS != URXE_PORTS)
      $error("PORTS must equal the register map port count.");
   if (DIV_W < 1 || DIV_W > 16)
      $error("DIV_W must lie between 1 and 16.");
   // The reset divisor must fit the chosen divider width.
   if (DIV_W < 16 && (URXE_DIV_RST >> DIV_W) != 16'h0000)
      $error("DIV_W too narrow for the reset divisor.");

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage and per-port receive state.
   logic [7:0] stn_addr_q [PORTS];
   logic [7:0] stn_mask_q [PORTS];
   urxe_cfg_t cfg_q [PORTS];
   logic [DIV_W-1:0] div_q [PORTS];
   logic [7:0] rbuf_q [PORTS];
   logic [PORTS-1:0] rc_q;
   logic [PORTS-1:0] fault_q;
   logic [PORTS-1:0] rb8_q;
   logic [2*PORTS-1:0] irq_stat_q;
   logic [2*PORTS-1:0] irq_mask_q;
   logic [PORTS-1:0] rc_set;
   logic [PORTS-1:0] fault_set;
   logic [PORTS-1:0] data_done;
   logic [PORTS-1:0] stop_done;
   logic [PORTS-1:0] match;
   urxe_frame_t frame [PORTS];
   logic [2*PORTS-1:0] irq_set;
   logic [2*PORTS-1:0] irq_stat_d;
   logic [31:0] rd_d;
   logic err_d;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [9:0] idx;
   logic setup;
   logic wr_acc;

   // Register selector, used by both the read and the write paths.
   function automatic logic [3:0] reg_sel(input logic [9:0] ix, output logic [0:0] port);
      port = 1'b0;
      reg_sel = SEL_NONE;
      case (ix)
         URXE_IDX_STN_ADDR0: reg_sel = SEL_ADDR;
         URXE_IDX_STN_ADDR1:
         begin
            reg_sel = SEL_ADDR;
            port = 1'b1;
         end
         URXE_IDX_STN_MASK0: reg_sel = SEL_MASK;
         URXE_IDX_STN_MASK1:
         begin
            reg_sel = SEL_MASK;
            port = 1'b1;
         end
         URXE_IDX_CTRL0, URXE_IDX_CTRL1:
         begin
            reg_sel = SEL_CTRL;
            port = ix[0];
         end
         URXE_IDX_STAT0, URXE_IDX_STAT0 + 10'h001:
         begin
            reg_sel = SEL_STAT;
            port = ix[0];
         end
         URXE_IDX_DATA0, URXE_IDX_DATA0 + 10'h001:
         begin
            reg_sel = SEL_DATA;
            port = ix[0];
         end
         URXE_IDX_DIV0, URXE_IDX_DIV1:
         begin
            reg_sel = SEL_DIV;
            port = ix[0];
         end
         URXE_IDX_IRQ_STAT: reg_sel = SEL_ISTAT;
         URXE_IDX_IRQ_MASK: reg_sel = SEL_IMASK;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // Write-one-to-clear strobe for one bit of one port's status register.
   function automatic logic stat_clr(input logic [9:0] ix, input logic [9:0] port,
      input logic [31:0] wd, input int unsigned pos);
      stat_clr = (ix == URXE_IDX_STAT0 + port) && wd[pos];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus phase decode.
   assign idx = i_paddr[11:2];
   assign setup = i_psel && !i_penable;
   assign wr_acc = i_psel && i_penable && i_pwrite && !pslverr_q; // Refused writes never land.

   // Zero wait states: the answer was prepared in the setup cycle.
   assign o_pready = i_psel && i_penable;
   // Read data and error come from flops; the error shows only in the access phase.
   assign o_prdata = prdata_q;
   assign o_pslverr = pslverr_q && i_psel && i_penable;

   // Read mux and unmapped-address check.
   always_comb
   begin
      logic [0:0] p;
      logic [3:0] s;
      p = 1'b0;
      s = reg_sel(idx, p);
      rd_d = 32'h0000_0000;
      err_d = (s == 4'h0) || (i_paddr[1:0] != 2'h0);
      case (s)
         SEL_ADDR: rd_d[7:0] = stn_addr_q[p];
         SEL_MASK: rd_d[7:0] = stn_mask_q[p];
         SEL_CTRL: rd_d[4:0] = cfg_q[p];
         SEL_STAT:
         begin
            rd_d[URXE_STAT_RC] = rc_q[p];
            rd_d[URXE_STAT_FAULT] = fault_q[p];
            rd_d[URXE_STAT_BIT9] = rb8_q[p];
         end
         SEL_DATA: rd_d[7:0] = rbuf_q[p];
         SEL_DIV: rd_d[DIV_W-1:0] = div_q[p];
         SEL_ISTAT: rd_d[2*PORTS-1:0] = irq_stat_q;
         SEL_IMASK: rd_d[2*PORTS-1:0] = irq_mask_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Answer captured in the setup cycle and held through the access phase.
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (setup)
      begin
         prdata_q <= i_pwrite ? 32'h0000_0000 : rd_d;
         pslverr_q <= err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software-written configuration registers.
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      logic [0:0] p;
      logic [3:0] s;
      if (!i_resetn)
      begin
         for (int i = 0; i < PORTS; i++)
         begin
            stn_addr_q[i] <= URXE_ADDR_RST;
            stn_mask_q[i] <= URXE_MASK_RST;
            cfg_q[i] <= '0;
            div_q[i] <= URXE_DIV_RST[DIV_W-1:0];
         end
         irq_mask_q <= '0;
      end
      else if (wr_acc)
      begin
         p = 1'b0;
         s = reg_sel(idx, p);
         case (s)
            SEL_ADDR: stn_addr_q[p] <= i_pwdata[7:0];
            SEL_MASK: stn_mask_q[p] <= i_pwdata[7:0];
            SEL_CTRL: cfg_q[p] <= i_pwdata[4:0];
            SEL_DIV: div_q[p] <= i_pwdata[DIV_W-1:0];
            SEL_IMASK: irq_mask_q <= i_pwdata[2*PORTS-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-port receiver, address compare and flag decision.
   for (genvar g = 0; g < PORTS; g++)
   begin : g_port
      // Decision signals of this port.
      logic defer;
      logic mpe_act;
      logic is_mode1;
      logic accept_data;
      logic accept_stop;
      logic clr_rc;
      logic clr_fault;

      // Receiver of this port, at its own rate.
      urxe_rx_engine #(
         .DIV_W(DIV_W)
      ) u_rx (
         .i_mclk(i_mclk),
         .i_resetn(i_resetn),
         .i_rxd(i_rxd[g]),
         .i_cfg(cfg_q[g]),
         .i_div(div_q[g]),
         .o_data_done(data_done[g]),
         .o_stop_done(stop_done[g]),
         .o_frame(frame[g])
      );

      // Address compare against this port's station pair.
      urxe_addr_match u_match (
         .i_rx_addr(frame[g].data),
         .i_station(stn_addr_q[g]),
         .i_mask(stn_mask_q[g]),
         .o_match(match[g])
      );

      // Mode 0 never runs address filtering.
      assign mpe_act = cfg_q[g].mpe && (cfg_q[g].mode != URXE_MODE_SYNC);
      assign is_mode1 = cfg_q[g].mode == URXE_MODE_1;
      // Decision waits for the stop bit when checking, or mode 1 filtering.
      assign defer = cfg_q[g].fce || (mpe_act && is_mode1);
      // Early decision at the last data bit: ninth bit one plus match.
      assign accept_data = data_done[g] && !defer &&
         (!mpe_act || (frame[g].bit9 && match[g]));
      // Late decision at the stop bit.
      assign accept_stop = stop_done[g] && defer &&
         (!mpe_act || (match[g] && (is_mode1 ? frame[g].stop : frame[g].bit9)));
      // Flag events; the fault needs checking switched on.
      assign rc_set[g] = accept_data || accept_stop;
      assign fault_set[g] = stop_done[g] && cfg_q[g].fce && !frame[g].stop;
      // Status clears, from granted writes only.
      assign clr_rc = wr_acc && stat_clr(idx, 10'(g), i_pwdata, URXE_STAT_RC);
      assign clr_fault = wr_acc && stat_clr(idx, 10'(g), i_pwdata, URXE_STAT_FAULT);

      // Status flags; a set in the clearing cycle wins.
      always_ff @(posedge i_mclk or negedge i_resetn)
      begin
         if (!i_resetn)
         begin
            rc_q[g] <= 1'b0;
            fault_q[g] <= 1'b0;
         end
         else
         begin
            rc_q[g] <= rc_set[g] || (rc_q[g] && !clr_rc);
            fault_q[g] <= fault_set[g] || (fault_q[g] && !clr_fault);
         end
      end

      // Accepted byte and its ninth bit; in mode 1 the last sampled stop level, from the previous frame unless deferred.
      always_ff @(posedge i_mclk or negedge i_resetn)
      begin
         if (!i_resetn)
         begin
            rbuf_q[g] <= 8'h00;
            rb8_q[g] <= 1'b0;
         end
         else if (rc_set[g])
         begin
            rbuf_q[g] <= frame[g].data;
            rb8_q[g] <= is_mode1 ? frame[g].stop : frame[g].bit9;
         end
      end

      // Interrupt events of this port, in status register layout.
      assign irq_set[2*g] = rc_set[g];
      assign irq_set[2*g+1] = fault_set[g];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status next value, write one to clear, set wins over clear.
   always_comb
   begin
      irq_stat_d = irq_set | irq_stat_q;
      if (wr_acc && idx == URXE_IDX_IRQ_STAT)
      begin
         irq_stat_d = irq_set | (irq_stat_q & ~i_pwdata[2*PORTS-1:0]);
      end
   end

   // Interrupt status register.
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         irq_stat_q <= '0;
      else
         irq_stat_q <= irq_stat_d;
   end

   // Level interrupt while any unmasked status bit is set.
   assign o_irq = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

// *** test/urxe_rx_enh_properties.sv ***
// Purpose: Concurrent checks on the register bus and the interrupt pin of the receive block.
// Assumes: One clock domain, reset active low.
// Notes: Attached to the top module by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module urxe_rx_enh_properties
import urxe_pkg::*;
#(
   parameter int unsigned PORTS = 2,
   parameter int unsigned DIV_W = 16
)
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [PORTS-1:0] i_rxd,
   input wire logic o_irq
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   logic acc;
   logic map_ok;
   // Access phase and decode of the mapped, aligned words.
   assign acc = i_psel && i_penable;
   assign map_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[11:2] inside {URXE_IDX_STN_ADDR0,
      URXE_IDX_STN_MASK0, URXE_IDX_STN_ADDR1, URXE_IDX_STN_MASK1,
      [URXE_IDX_CTRL0:URXE_IDX_IRQ_MASK]});
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_access:
      assert property (acc |-> o_pready) else $error("pready missing in access");
   a_ready_only_access:
      assert property (o_pready |-> acc) else $error("pready outside access");
   a_err_bad_addr:
      assert property ((acc && !map_ok) |-> o_pslverr) else $error("no error on bad address");
   a_err_good_addr:
      assert property ((acc && map_ok) |-> !o_pslverr) else $error("error on mapped address");
   a_err_in_access:
      assert property (o_pslverr |-> acc) else $error("pslverr outside access");
   a_rdata_holds:
      assert property (acc |=> $stable(o_prdata)) else $error("read data moved after access");
   a_irq_fall_write:
      assert property ($fell(o_irq) |-> $past(acc && i_pwrite)) else $error("irq fell alone");
   a_irq_mask_off:
      assert property ((acc && i_pwrite && i_paddr[11:2] == URXE_IDX_IRQ_MASK
         && i_pwdata[3:0] == 4'h0) |=> (!o_irq) [*2]) else $error("irq high while masked");
endmodule
bind urxe_rx_enh urxe_rx_enh_properties #(.PORTS(PORTS), .DIV_W(DIV_W)) u_props
(
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rxd(i_rxd), .o_irq(o_irq)
);
`default_nettype wire

// *** test/urxe_line_node.sv ***
// Purpose: Remote serial node that sends frames onto one receive line.
// Assumes: Divisor zero, so one bit lasts 16 clocks.
// Notes: The line rests at the idle high level between frames.
`timescale 1ns/1ps
`default_nettype none
module urxe_line_node
(
   input wire logic i_mclk,
   output logic o_line
);
   initial o_line = 1'b1;
   // Start bit, nbits data bits LSB first, then the chosen stop level.
   task automatic send(input logic [8:0] v, input int nbits, input logic stop_lvl);
      for (int i = -1; i <= nbits; i++)
      begin
         o_line <= (i < 0) ? 1'b0 : ((i == nbits) ? stop_lvl : v[i]);
         repeat (16) @(posedge i_mclk);
      end
      o_line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** test/urxe_rx_enh_tb.sv ***
// Purpose: Self-checking bench for the enhanced receive block.
// Assumes: Two remote nodes drive the lines; divisor set to zero.
// Notes: Reads note their expectation in a queue; a monitor compares.
`timescale 1ns/1ps
`default_nettype none
module urxe_rx_enh_tb;
   import urxe_pkg::*;
   logic i_mclk, i_resetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   wire logic [1:0] rxd;
   logic [32:0] exp_q[$];
   logic [7:0] r;
   logic [8:0] tv[6] = '{9'h1f0, 9'h1f3, 9'h1ff, 9'h1fb, 9'h100, 9'h0f1};
   logic [5:0] te = 6'b001101;
   int err_count = 0;
   int tests_run = 0;
   urxe_rx_enh u_dut(.i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_irq(irq));
   urxe_line_node u_node0(.i_mclk(i_mclk), .o_line(rxd[0]));
   urxe_line_node u_node1(.i_mclk(i_mclk), .o_line(rxd[1]));
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running clock.
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
      begin
         $display("*** PASS ***");
      end
      else
      begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One bus transfer; waits for pready under a bound.
   task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge i_mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge i_mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_count++;
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb({idx, 2'b00}, 1'b1, d);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [31:0] e);
      exp_q.push_back({1'b0, e});
      apb({idx, 2'b00}, 1'b0, 32'h0);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge i_mclk);
      chk({32'h0, irq}, {32'h0, e});
      @(posedge i_mclk);
   endtask
   // Sends one frame on port 1 and expects the receive-complete bit in irq status.
   task automatic rx1(input logic [8:0] v, input int nb, input logic s, input logic e);
      u_node1.send(v, nb, s);
      repeat (20) @(posedge i_mclk);
      rd(URXE_IDX_IRQ_STAT, {29'h0, e, 2'b00});
      wr(URXE_IDX_IRQ_STAT, 32'h4);
   endtask
   function automatic logic em(input logic [7:0] x, input logic [7:0] s, input logic [7:0] m);
      return (((x ^ s) & m) == 8'h0) || ((~x & (s | m)) == 8'h0);
   endfunction
   // Monitor: each completed read is compared with the oldest note.
   always @(posedge i_mclk)
   begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      begin
         chk({pslverr, prdata}, exp_q.pop_front());
      end
   end
   // Watchdog against a hang.
   initial
   begin
      repeat (100000) @(posedge i_mclk);
      err_count++;
      wrap_up();
   end
   // Main sequence.
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      i_resetn = 1'b0;
      r = 8'($urandom(32'h376aeeb5));
      repeat (8) @(posedge i_mclk);
      i_resetn <= 1'b1;
      @(posedge i_mclk);
      foreach (tv[i])
         rd(tv[i][0] ? URXE_IDX_STN_ADDR1 : URXE_IDX_STN_MASK1, 32'h0);
      rd(URXE_IDX_STN_ADDR0, 32'h0);
      exp_q.push_back({1'b1, 32'h0});
      apb(12'h001, 1'b0, 32'h0);
      wr(URXE_IDX_STN_ADDR0, 32'h11);
      rd(URXE_IDX_STN_ADDR0, 32'h11);
      rd(URXE_IDX_STN_ADDR1, 32'h0);
      $display("test registers done");
      wr(URXE_IDX_DIV0, 32'h0);
      wr(URXE_IDX_CTRL0, 32'h11);
      fork
         u_node0.send(9'h0a5, 8, 1'b1);
         begin repeat (145) @(posedge i_mclk); rd(URXE_IDX_DATA0, 32'ha5); end
      join
      repeat (20) @(posedge i_mclk);
      wr(URXE_IDX_CTRL0, 32'h19);
      fork
         u_node0.send(9'h03c, 8, 1'b1);
         begin repeat (145) @(posedge i_mclk); rd(URXE_IDX_DATA0, 32'ha5); end
      join
      repeat (20) @(posedge i_mclk);
      wr(URXE_IDX_STAT0, 32'h3);
      u_node0.send(9'h081, 8, 1'b0);
      repeat (20) @(posedge i_mclk);
      rd(URXE_IDX_STAT0, 32'h3);
      wr(URXE_IDX_STAT0, 32'h1);
      u_node0.send(9'h042, 8, 1'b1);
      repeat (20) @(posedge i_mclk);
      rd(URXE_IDX_STAT0, 32'h7);
      wr(URXE_IDX_IRQ_MASK, 32'h2);
      chk_irq(1'b1);
      wr(URXE_IDX_IRQ_MASK, 32'h0);
      chk_irq(1'b0);
      wr(URXE_IDX_IRQ_MASK, 32'h2);
      wr(URXE_IDX_IRQ_STAT, 32'hf);
      chk_irq(1'b0);
      wr(URXE_IDX_STAT0, 32'h3);
      rd(URXE_IDX_STAT0, 32'h4);
      $display("test framing done");
      wr(URXE_IDX_DIV1, 32'h0);
      wr(URXE_IDX_CTRL1, 32'h14);
      rx1(9'h100, 8, 1'b1, 1'b0);
      wr(URXE_IDX_CTRL1, 32'h17);
      rx1(9'h100, 9, 1'b1, 1'b1);
      wr(URXE_IDX_STN_ADDR1, 32'hf1);
      wr(URXE_IDX_STN_MASK1, 32'hfa);
      foreach (tv[i]) rx1(tv[i], 9, 1'b1, te[i]);
      wr(URXE_IDX_CTRL1, 32'h15);
      rx1(9'h0f0, 8, 1'b1, 1'b1);
      rx1(9'h0f0, 8, 1'b0, 1'b0);
      $display("test address match done");
      wr(URXE_IDX_CTRL1, 32'h17);
      wr(URXE_IDX_STN_MASK1, 32'hff);
      repeat (3)
      begin
         r = 8'($urandom);
         wr(URXE_IDX_STN_ADDR1, {24'h0, r});
         rx1({1'b1, r}, 9, 1'b1, 1'b1);
         rx1({1'b1, r ^ 8'h01}, 9, 1'b1, em(r ^ 8'h01, r, 8'hff));
      end
      $display("test exact mask done");
      wrap_up();
   end
endmodule
`default_nettype wire
